// [common/ebp_pkg.sv]
package ebp_pkg;

    // Register byte offsets on the APB side.
    localparam logic [11:0] EBP_CTRL_OFS = 12'h000;
    localparam logic [11:0] EBP_STATUS_OFS = 12'h004;
    localparam logic [11:0] EBP_DIR_LO_OFS = 12'h008;
    localparam logic [11:0] EBP_DIR_HI_OFS = 12'h00C;
    localparam logic [11:0] EBP_OUT_LO_OFS = 12'h010;
    localparam logic [11:0] EBP_OUT_HI_OFS = 12'h014;
    localparam logic [11:0] EBP_PIN_LO_OFS = 12'h018;
    localparam logic [11:0] EBP_PIN_HI_OFS = 12'h01C;
    localparam logic [11:0] EBP_PULLUP_OFS = 12'h020;
    localparam logic [11:0] EBP_ADDR_OFS = 12'h024;
    localparam logic [11:0] EBP_WDATA_OFS = 12'h028;
    localparam logic [11:0] EBP_CMD_OFS = 12'h02C;
    localparam logic [11:0] EBP_RDATA_OFS = 12'h030;

    // Control register fields.
    localparam int EBP_CTRL_BUS_EN_BIT = 0;
    localparam int EBP_CTRL_MUX_BIT = 1;
    localparam int EBP_CTRL_SINGLE_BIT = 2;
    localparam int EBP_CTRL_W = 3;
    localparam logic [2:0] EBP_CTRL_RST = 3'h0;

    // Command register fields.
    localparam int EBP_CMD_GO_BIT = 0;
    localparam int EBP_CMD_WRITE_BIT = 1;
    localparam int EBP_CMD_WORD_BIT = 2;

    // Status register fields.
    localparam int EBP_ST_MPMODE_BIT = 0;
    localparam int EBP_ST_NARROW_BIT = 1;
    localparam int EBP_ST_HOLD_BIT = 2;
    localparam int EBP_ST_BUSY_BIT = 3;
    localparam int EBP_ST_OWN_BIT = 4;

    // Address register layout: 20 address bits, then the space select.
    localparam int EBP_ADDR_W = 20;
    localparam int EBP_SPACE_LSB = 20;

    // Reset values of the port and pull-up registers.
    localparam logic [7:0] EBP_DIR_RST = 8'h00;
    localparam logic [7:0] EBP_OUT_RST = 8'h00;
    localparam logic [9:0] EBP_PULLUP_RST = 10'h000;

    // Length of the read or write strobe in clock cycles.
    localparam logic [1:0] EBP_STROBE_CYCLES = 2'h2;

    typedef enum logic [2:0] {
        EBP_IDLE = 3'b000,
        EBP_ADDR = 3'b001,
        EBP_STRB = 3'b010,
        EBP_END = 3'b011,
        EBP_HOLD = 3'b100
    } ebp_state_type;

endpackage

// [src/ebp_port_bus.sv]
// Functional notes
// - BYTE-width pin low means 16-bit bus.
// - Mode pin high selects microprocessor operation.
// - Low reset input holds device in reset.
// - Per-pin direction bit for every port.
// - Input pull-ups enabled per four-bit group.
// - Ports one to four act like port zero.
// - Separate bus: data on ports zero, one.
// - Separate bus: address low, middle bytes out.
// - 8-bit multiplexed: port two shares address/data.
// - 16-bit multiplexed: A0 alone, rest shared.
// - 16-bit multiplexed: A8/D7 shared, A9-A15 driven.
// - Port three drives address bits 8-15.
// - Port four: chip selects and A16-A19.
// - Twenty-bit address across ports two to four.
// - Byte-lane strobes: even low, odd high.
// - Single strobe: upper-lane enable marks odd.
// - Address latch pulses in multiplexed address phase.
// - Yield request low holds bus, ack low.
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module ebp_port_bus
    import ebp_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic BUS_WIDTH_SEL,
    input wire logic PROCESSOR_MODE_SELECT,
    input wire logic BUS_YIELD_REQ_N,
    output logic BUS_YIELD_ACK_N,
    output logic ADDR_LATCH,
    output logic READ_STROBE_N,
    output logic LOW_LANE_STORE_N,
    output logic HIGH_LANE_STORE_N,
    input wire logic [7:0] PORT_ZERO_IN,
    output logic [7:0] PORT_ZERO_OUT,
    output logic [7:0] PORT_ZERO_OE,
    output logic [7:0] PORT_ZERO_PULL_EN,
    input wire logic [7:0] PORT_ONE_IN,
    output logic [7:0] PORT_ONE_OUT,
    output logic [7:0] PORT_ONE_OE,
    output logic [7:0] PORT_ONE_PULL_EN,
    input wire logic [7:0] PORT_TWO_IN,
    output logic [7:0] PORT_TWO_OUT,
    output logic [7:0] PORT_TWO_OE,
    output logic [7:0] PORT_TWO_PULL_EN,
    input wire logic [7:0] PORT_THREE_IN,
    output logic [7:0] PORT_THREE_OUT,
    output logic [7:0] PORT_THREE_OE,
    output logic [7:0] PORT_THREE_PULL_EN,
    input wire logic [7:0] PORT_FOUR_IN,
    output logic [7:0] PORT_FOUR_OUT,
    output logic [7:0] PORT_FOUR_OE,
    output logic [7:0] PORT_FOUR_PULL_EN
);

    ////////////////////////////////////////////////////////////////////////////
    // State and register declarations.

    ebp_state_type state_q;
    logic narrow_q;
    logic mp_mode_q;
    logic [2:0] ctrl_q;
    logic [4:0][7:0] dir_q;
    logic [4:0][7:0] out_q;
    logic [9:0] pullup_q;
    logic [21:0] addr_q;
    logic [15:0] wdata_q;
    logic [15:0] rdata_q;
    logic cmd_write_q;
    logic cmd_word_q;
    logic pending_q;
    logic [1:0] cnt_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic [4:0][7:0] pin_in;
    logic [4:0][7:0] bus_own;
    logic [4:0][7:0] bus_oe;
    logic [4:0][7:0] bus_out;
    logic [4:0][7:0] pin_out;
    logic [4:0][7:0] pin_oe;
    logic [4:0][7:0] pull_en;
    logic apb_wr;
    logic apb_setup;
    logic bus_assigned;
    logic mux_mode;
    logic single_strobe;
    logic hold;
    logic active;
    logic data_ph;
    logic drive_data;
    logic [1:0] lanes;
    logic go;
    logic [3:0] space_n;

    // Lane decode: bit 0 low lane, bit 1 high lane. A narrow bus never takes both lanes; A0 picks the one.
    function automatic logic [1:0] lane_decode(input logic a0, input logic word, input logic narrow);
        logic [1:0] l;
        l = 2'h0;
        if (word && !narrow) begin
            l = 2'h3;
        end else if (a0) begin
            l = 2'h2;
        end else begin
            l = 2'h1;
        end
        return l;
    endfunction

    assign pin_in = {PORT_FOUR_IN, PORT_THREE_IN, PORT_TWO_IN, PORT_ONE_IN, PORT_ZERO_IN};
    assign apb_wr = PSEL && PENABLE && PWRITE;
    assign apb_setup = PSEL && !PENABLE;
    assign mux_mode = ctrl_q[EBP_CTRL_MUX_BIT];
    assign single_strobe = ctrl_q[EBP_CTRL_SINGLE_BIT];
    // Microprocessor mode always hands the ports to the bus; otherwise software decides.
    assign bus_assigned = mp_mode_q || ctrl_q[EBP_CTRL_BUS_EN_BIT];
    assign hold = (state_q == EBP_HOLD);
    assign active = (state_q == EBP_ADDR) || (state_q == EBP_STRB) || (state_q == EBP_END);
    assign data_ph = (state_q == EBP_STRB) || (state_q == EBP_END);
    assign drive_data = data_ph && cmd_write_q;
    assign lanes = lane_decode(addr_q[0], cmd_word_q, narrow_q);
    // A command is refused while a cycle is pending or the ports are not on the bus.
    assign go = apb_wr && (PADDR == EBP_CMD_OFS) && PWDATA[EBP_CMD_GO_BIT] && !pending_q && bus_assigned;
    assign space_n = active ? ~(4'h1 << addr_q[21:20]) : 4'hF;

    ////////////////////////////////////////////////////////////////////////////
    // Strap capture. Width and mode pins are sampled while reset is held low.

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            narrow_q <= BUS_WIDTH_SEL;
            mp_mode_q <= PROCESSOR_MODE_SELECT;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software registers.

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            ctrl_q <= EBP_CTRL_RST;
            dir_q <= {5{EBP_DIR_RST}};
            out_q <= {5{EBP_OUT_RST}};
            pullup_q <= EBP_PULLUP_RST;
            addr_q <= 22'h0;
            wdata_q <= 16'h0;
        end else if (apb_wr) begin
            case (PADDR)
                EBP_CTRL_OFS: ctrl_q <= PWDATA[2:0];
                EBP_DIR_LO_OFS: dir_q[3:0] <= PWDATA;
                EBP_DIR_HI_OFS: dir_q[4] <= PWDATA[7:0];
                EBP_OUT_LO_OFS: out_q[3:0] <= PWDATA;
                EBP_OUT_HI_OFS: out_q[4] <= PWDATA[7:0];
                EBP_PULLUP_OFS: pullup_q <= PWDATA[9:0];
                EBP_ADDR_OFS: addr_q <= PWDATA[21:0];
                EBP_WDATA_OFS: wdata_q <= PWDATA[15:0];
                default: ;
            endcase
        end
    end

    // Command latch; the access kind is frozen for the whole cycle.
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            cmd_write_q <= 1'b0;
            cmd_word_q <= 1'b0;
        end else if (go) begin
            cmd_write_q <= PWDATA[EBP_CMD_WRITE_BIT];
            cmd_word_q <= PWDATA[EBP_CMD_WORD_BIT];
        end
    end

    // APB read data and error are registered in the setup cycle, so the access phase needs no wait.
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            prdata_q <= 32'h0;
            pslverr_q <= 1'b0;
        end else if (apb_setup) begin
            pslverr_q <= 1'b0;
            case (PADDR)
                EBP_CTRL_OFS: prdata_q <= {29'h0, ctrl_q};
                EBP_STATUS_OFS: prdata_q <= {27'h0, bus_assigned, pending_q, hold, narrow_q, mp_mode_q};
                EBP_DIR_LO_OFS: prdata_q <= dir_q[3:0];
                EBP_DIR_HI_OFS: prdata_q <= {24'h0, dir_q[4]};
                EBP_OUT_LO_OFS: prdata_q <= out_q[3:0];
                EBP_OUT_HI_OFS: prdata_q <= {24'h0, out_q[4]};
                EBP_PIN_LO_OFS: prdata_q <= pin_in[3:0];
                EBP_PIN_HI_OFS: prdata_q <= {24'h0, pin_in[4]};
                EBP_PULLUP_OFS: prdata_q <= {22'h0, pullup_q};
                EBP_ADDR_OFS: prdata_q <= {10'h0, addr_q};
                EBP_WDATA_OFS: prdata_q <= {16'h0, wdata_q};
                EBP_CMD_OFS: prdata_q <= 32'h0;
                EBP_RDATA_OFS: prdata_q <= {16'h0, rdata_q};
                default: begin
                    prdata_q <= 32'h0;
                    pslverr_q <= 1'b1;
                end
            endcase
        end
    end

    assign PRDATA = prdata_q;
    assign PSLVERR = pslverr_q && PSEL && PENABLE;
    assign PREADY = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // Bus cycle sequencer. A yield request is granted only between cycles so that
    // a strobe is never cut short.

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            state_q <= EBP_IDLE;
            cnt_q <= 2'h0;
        end else begin
            case (state_q)
                EBP_IDLE: begin
                    if (!BUS_YIELD_REQ_N) begin
                        state_q <= EBP_HOLD;
                    end else if (pending_q) begin
                        state_q <= EBP_ADDR;
                    end
                end
                EBP_ADDR: begin
                    state_q <= EBP_STRB;
                    cnt_q <= EBP_STROBE_CYCLES - 2'h1;
                end
                EBP_STRB: begin
                    if (cnt_q == 2'h0) begin
                        state_q <= EBP_END;
                    end else begin
                        cnt_q <= cnt_q - 2'h1;
                    end
                end
                EBP_END: state_q <= EBP_IDLE;
                EBP_HOLD: begin
                    if (BUS_YIELD_REQ_N) begin
                        state_q <= EBP_IDLE;
                    end
                end
                default: state_q <= EBP_IDLE;
            endcase
        end
    end

    // Pending flag: set by a command, cleared when the cycle closes.
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            pending_q <= 1'b0;
        end else if (go) begin
            pending_q <= 1'b1;
        end else if (state_q == EBP_END) begin
            pending_q <= 1'b0;
        end
    end

    // Read data is taken on the last strobe cycle, from the lanes that carry data.
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            rdata_q <= 16'h0;
        end else if (state_q == EBP_STRB && cnt_q == 2'h0 && !cmd_write_q) begin
            if (!mux_mode) begin
                rdata_q <= {narrow_q ? 8'h00 : pin_in[1], pin_in[0]};
            end else if (narrow_q) begin
                rdata_q <= {8'h00, pin_in[2]};
            end else begin
                rdata_q <= {8'h00, pin_in[3][0], pin_in[2][7:1]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin assignment for the bus. During hold every bus pin is released.

    always_comb begin
        bus_own = '0;
        bus_oe = '0;
        bus_out = '0;
        if (bus_assigned) begin
            bus_own[4] = 8'hFF;
            bus_oe[4] = {8{!hold}};
            bus_out[4] = {addr_q[19:16], space_n};
            bus_own[3] = 8'hFF;
            bus_oe[3] = {8{!hold}};
            bus_out[3] = addr_q[15:8];
            bus_own[2] = 8'hFF;
            bus_oe[2] = {8{!hold}};
            if (!mux_mode) begin
                bus_out[2] = addr_q[7:0];
                bus_own[0] = 8'hFF;
                bus_oe[0] = {8{drive_data}};
                bus_out[0] = wdata_q[7:0];
                if (!narrow_q) begin
                    bus_own[1] = 8'hFF;
                    bus_oe[1] = {8{drive_data}};
                    bus_out[1] = wdata_q[15:8];
                end
            end else if (narrow_q) begin
                bus_out[2] = data_ph ? wdata_q[7:0] : addr_q[7:0];
                bus_oe[2] = {8{!hold && (!data_ph || cmd_write_q)}};
            end else begin
                bus_out[2] = data_ph ? {wdata_q[6:0], addr_q[0]} : addr_q[7:0];
                bus_oe[2] = {{7{!hold && (!data_ph || cmd_write_q)}}, !hold};
                bus_out[3] = {addr_q[15:9], data_ph ? wdata_q[7] : addr_q[8]};
                bus_oe[3] = {{7{!hold}}, !hold && (!data_ph || cmd_write_q)};
            end
        end
    end

    // Pins not owned by the bus follow the general port registers.
    always_comb begin
        for (int p = 0; p < 5; p++) begin
            pin_out[p] = (bus_own[p] & bus_out[p]) | (~bus_own[p] & out_q[p]);
            pin_oe[p] = (bus_own[p] & bus_oe[p]) | (~bus_own[p] & dir_q[p]);
            pull_en[p] = {{4{pullup_q[2 * p + 1]}}, {4{pullup_q[2 * p]}}} & ~pin_oe[p];
        end
    end

    assign {PORT_FOUR_OUT, PORT_THREE_OUT, PORT_TWO_OUT, PORT_ONE_OUT, PORT_ZERO_OUT} = pin_out;
    assign {PORT_FOUR_OE, PORT_THREE_OE, PORT_TWO_OE, PORT_ONE_OE, PORT_ZERO_OE} = pin_oe;
    assign {PORT_FOUR_PULL_EN, PORT_THREE_PULL_EN, PORT_TWO_PULL_EN, PORT_ONE_PULL_EN, PORT_ZERO_PULL_EN} = pull_en;

    ////////////////////////////////////////////////////////////////////////////
    // Bus strobes. The high pin doubles as the upper-lane enable in single strobe mode.

    assign ADDR_LATCH = (state_q == EBP_ADDR) && mux_mode;
    assign READ_STROBE_N = !(state_q == EBP_STRB && !cmd_write_q);
    assign LOW_LANE_STORE_N = single_strobe ? !(state_q == EBP_STRB && cmd_write_q)
                                            : !(state_q == EBP_STRB && cmd_write_q && lanes[0]);
    assign HIGH_LANE_STORE_N = single_strobe ? !(active && addr_q[0])
                                             : !(state_q == EBP_STRB && cmd_write_q && lanes[1]);
    assign BUS_YIELD_ACK_N = !hold;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    AST_ALE_PULSE: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (state_q == EBP_ADDR && mux_mode) |-> ADDR_LATCH ##1 !ADDR_LATCH)
        else $error("Address latch did not pulse for one cycle.");

    AST_HOLD_ACK: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (state_q == EBP_IDLE && !BUS_YIELD_REQ_N) |=> (!BUS_YIELD_ACK_N && (!bus_assigned || PORT_FOUR_OE == 8'h00)))
        else $error("Hold request not acknowledged with pins released.");

    AST_EVEN_LOW_LANE: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (!single_strobe && state_q == EBP_STRB && cmd_write_q && !cmd_word_q && !addr_q[0])
        |-> (!LOW_LANE_STORE_N && HIGH_LANE_STORE_N))
        else $error("Even byte write used the wrong lane strobe.");

    AST_ODD_UPPER_ENABLE: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (single_strobe && active) |-> (HIGH_LANE_STORE_N == !addr_q[0]))
        else $error("Upper-lane enable does not follow address bit 0.");

    AST_MUX_ORDER: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (state_q == EBP_ADDR && mux_mode && narrow_q && !cmd_write_q)
        |-> (PORT_TWO_OUT == addr_q[7:0] && PORT_TWO_OE == 8'hFF) ##1 (PORT_TWO_OE == 8'h00 && !READ_STROBE_N))
        else $error("Multiplexed read did not turn from address to released pins.");

    AST_SEP_ADDRESS: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (bus_assigned && !mux_mode && active) |-> (PORT_TWO_OUT == addr_q[7:0] && PORT_THREE_OUT == addr_q[15:8]))
        else $error("Separate bus address bytes wrong.");

    AST_SPACE_SELECT: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (bus_assigned && active) |-> (PORT_FOUR_OUT == {addr_q[19:16], ~(4'h1 << addr_q[21:20])}))
        else $error("Chip select or high address wrong.");

    AST_GENERAL_PORT: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        !bus_assigned |-> (PORT_ONE_OE == dir_q[1] && PORT_THREE_OUT == out_q[3]))
        else $error("Unassigned port does not follow its registers.");

    AST_A0_ALONE: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (bus_assigned && mux_mode && !narrow_q && active) |-> (PORT_TWO_OUT[0] == addr_q[0] && PORT_TWO_OE[0]))
        else $error("Address bit 0 not driven alone.");

    AST_STROBE_LEN: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (state_q == EBP_ADDR) |=> (state_q == EBP_STRB) [*2] ##1 (state_q == EBP_END))
        else $error("Strobe length wrong.");

endmodule
`default_nettype wire

// [dv/ebp_mem_model.sv]
`timescale 1ns/1ns
`default_nettype none
module ebp_mem_model (
    input wire logic clk,
    input wire logic muxed,
    input wire logic [4:0][7:0] pout,
    input wire logic [4:0][7:0] poe,
    input wire logic [4:0][7:0] ppu,
    input wire logic ale,
    input wire logic rd_n,
    input wire logic lo_n,
    input wire logic hi_n,
    output logic [4:0][7:0] pin_lvl,
    output logic [19:0] cap_addr,
    output logic [3:0] cap_cs,
    output logic saw_ale,
    output logic saw_lo,
    output logic saw_hi
);
    logic [7:0] mem [0:15];
    logic [3:0] cs_prev;
    logic tog = 1'b0;
    logic [3:0] ev;
    logic [3:0] od;

    ////////////////////////////////////////////////////////////////////////////////
    // A released pin without pull-up flickers, so a stale value can never pass for data.
    function automatic logic [7:0] lvl(input logic [7:0] o, e, u, d, input logic den);
        return (e & o) | (~e & (den ? d : (u | {8{tog}})));
    endfunction

    // Pin levels: the memory drives the data lanes only while the read strobe is low.
    always_comb begin
        ev = {cap_addr[3:1], 1'b0};
        od = {cap_addr[3:1], 1'b1};
        pin_lvl[0] = lvl(pout[0], poe[0], ppu[0], mem[ev], !rd_n && !muxed);
        pin_lvl[1] = lvl(pout[1], poe[1], ppu[1], mem[od], !rd_n && !muxed);
        pin_lvl[2] = lvl(pout[2], poe[2], ppu[2], mem[cap_addr[3:0]], !rd_n && muxed);
        pin_lvl[3] = lvl(pout[3], poe[3], ppu[3], 8'h00, 1'b0);
        pin_lvl[4] = lvl(pout[4], poe[4], ppu[4], 8'h00, 1'b0);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // The address is taken when a select falls, and the low byte again on the latch pulse.
    always_ff @(posedge clk) begin
        tog <= ~tog;
        cs_prev <= pout[4][3:0];
        if (cs_prev == 4'hF && pout[4][3:0] != 4'hF) begin
            cap_addr <= {pout[4][7:4], pout[3], pout[2]};
            cap_cs <= pout[4][3:0];
            saw_ale <= ale;
            saw_lo <= 1'b0;
            saw_hi <= 1'b0;
        end
        if (ale) begin
            cap_addr[7:0] <= pout[2];
        end
        if (!lo_n) begin
            saw_lo <= 1'b1;
            mem[muxed ? cap_addr[3:0] : ev] <= muxed ? pout[2] : pout[0];
        end
        if (!hi_n) begin
            saw_hi <= 1'b1;
            if (!muxed) begin
                mem[od] <= pout[1];
            end
        end
    end
endmodule
`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb
    import ebp_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, ack_n, ale, rd_n, lo_n, hi_n;
    logic width_sel = 1'b1, mode_sel = 1'b0, yield_n = 1'b1, muxed = 1'b1;
    // Each port drives its own byte of these, so they are nets with several drivers.
    wire logic [4:0][7:0] pout, poe, ppu;
    logic [4:0][7:0] pin_lvl;
    logic [19:0] cap_addr;
    logic [3:0] cap_cs;
    logic saw_ale, saw_lo, saw_hi;
    int errors = 0;
    int total_checks = 0;

    ebp_port_bus u_dut (.CORE_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .BUS_WIDTH_SEL(width_sel), .PROCESSOR_MODE_SELECT(mode_sel), .BUS_YIELD_REQ_N(yield_n),
        .BUS_YIELD_ACK_N(ack_n), .ADDR_LATCH(ale), .READ_STROBE_N(rd_n), .LOW_LANE_STORE_N(lo_n),
        .HIGH_LANE_STORE_N(hi_n),
        .PORT_ZERO_IN(pin_lvl[0]), .PORT_ZERO_OUT(pout[0]), .PORT_ZERO_OE(poe[0]), .PORT_ZERO_PULL_EN(ppu[0]),
        .PORT_ONE_IN(pin_lvl[1]), .PORT_ONE_OUT(pout[1]), .PORT_ONE_OE(poe[1]), .PORT_ONE_PULL_EN(ppu[1]),
        .PORT_TWO_IN(pin_lvl[2]), .PORT_TWO_OUT(pout[2]), .PORT_TWO_OE(poe[2]), .PORT_TWO_PULL_EN(ppu[2]),
        .PORT_THREE_IN(pin_lvl[3]), .PORT_THREE_OUT(pout[3]), .PORT_THREE_OE(poe[3]),
        .PORT_THREE_PULL_EN(ppu[3]),
        .PORT_FOUR_IN(pin_lvl[4]), .PORT_FOUR_OUT(pout[4]), .PORT_FOUR_OE(poe[4]), .PORT_FOUR_PULL_EN(ppu[4]));

    ebp_mem_model u_mem (.clk(clk), .muxed(muxed), .pout(pout), .poe(poe), .ppu(ppu), .ale(ale), .rd_n(rd_n),
        .lo_n(lo_n), .hi_n(hi_n), .pin_lvl(pin_lvl), .cap_addr(cap_addr), .cap_cs(cap_cs),
        .saw_ale(saw_ale), .saw_lo(saw_lo), .saw_hi(saw_hi));

    ////////////////////////////////////////////////////////////////////////////////
    // The clock runs at 125 MHz.
    initial begin
        forever #4 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; an idle edge comes first so no signal is assigned twice in one step.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdm(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd & m, exp);
    endtask

    // Polls the busy flag with a bound, since a bus cycle may be held off by a yield request.
    task automatic wait_idle;
        int n = 0;
        do begin
            apb(1'b0, EBP_STATUS_OFS, 32'h0);
            n++;
        end while (rd[EBP_ST_BUSY_BIT] !== 1'b0 && n < 30);
        chk({31'h0, rd[EBP_ST_BUSY_BIT]}, 32'h0);
    endtask

    task automatic do_reset(input logic w, input logic m);
        rst_n <= 1'b0;
        width_sel <= w;
        mode_sel <= m;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
    endtask

    task automatic print_verdict;
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: registers, general ports, multiplexed bus, hold, then a 16-bit restart.
    initial begin
        do_reset(1'b1, 1'b0);
        rdm(EBP_STATUS_OFS, 32'hFFFFFFFF, 32'h2);
        rdm(EBP_DIR_LO_OFS, 32'hFFFFFFFF, 32'h0);
        rdm(EBP_PULLUP_OFS, 32'hFFFFFFFF, 32'h0);
        rdm(12'h040, 32'hFFFFFFFF, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, EBP_DIR_LO_OFS, 32'hA5C30FF0);
        apb(1'b1, EBP_OUT_LO_OFS, 32'h12345678);
        apb(1'b1, EBP_DIR_HI_OFS, 32'h3C);
        apb(1'b1, EBP_OUT_HI_OFS, 32'h99);
        apb(1'b1, EBP_PULLUP_OFS, 32'h2AA);
        // The pull-up write lands at the edge that ends the task, so let it settle first.
        @(posedge clk);
        chk({poe[3], poe[2], poe[1], poe[0]}, 32'hA5C30FF0);
        chk({pout[3], pout[2], pout[1], pout[0]} & 32'hA5C30FF0, 32'h12345678 & 32'hA5C30FF0);
        chk({16'h0, poe[4], pout[4] & 8'h3C}, 32'h3C18);
        chk({ppu[3], ppu[2], ppu[1], ppu[0]}, 32'h5030F000);
        rdm(EBP_PIN_LO_OFS, 32'hF5F3FFF0, (32'h12345678 & 32'hA5C30FF0) | 32'h5030F000);
        // Eight-bit multiplexed bus with byte-lane strobes: write, then read back.
        apb(1'b1, EBP_CTRL_OFS, 32'h3);
        apb(1'b1, EBP_ADDR_OFS, 32'h2ABCDE);
        apb(1'b1, EBP_WDATA_OFS, 32'h5A);
        apb(1'b1, EBP_CMD_OFS, 32'h3);
        wait_idle;
        chk({8'h0, cap_cs, cap_addr}, {8'h0, 4'b1011, 20'hABCDE});
        chk({31'h0, saw_ale}, 32'h1);
        chk({28'h0, pout[4][3:0]}, 32'hF);
        apb(1'b1, EBP_CMD_OFS, 32'h1);
        wait_idle;
        rdm(EBP_RDATA_OFS, 32'hFF, 32'h5A);
        // Single write strobe mode, odd address.
        apb(1'b1, EBP_CTRL_OFS, 32'h7);
        apb(1'b1, EBP_ADDR_OFS, 32'h100011);
        apb(1'b1, EBP_CMD_OFS, 32'h3);
        wait_idle;
        chk({26'h0, cap_cs, saw_lo, saw_hi}, {26'h0, 4'b1101, 2'b11});
        // Bus yield: the acknowledge falls and the shared pins are released.
        yield_n <= 1'b0;
        repeat (3) @(posedge clk);
        chk({23'h0, ack_n, poe[2]}, 32'h0);
        rdm(EBP_STATUS_OFS, 32'h4, 32'h4);
        yield_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk({31'h0, ack_n}, 32'h1);
        // Mid-run reset into microprocessor mode with a 16-bit separate bus.
        muxed <= 1'b0;
        do_reset(1'b0, 1'b1);
        rdm(EBP_STATUS_OFS, 32'hFFFFFFFF, 32'h11);
        rdm(EBP_CTRL_OFS, 32'hFFFFFFFF, 32'h0);
        chk({24'h0, poe[3]}, 32'hFF);
        apb(1'b1, EBP_ADDR_OFS, 32'h10);
        apb(1'b1, EBP_WDATA_OFS, 32'hBEEF);
        apb(1'b1, EBP_CMD_OFS, 32'h7);
        wait_idle;
        chk({30'h0, saw_lo, saw_hi}, 32'h3);
        apb(1'b1, EBP_ADDR_OFS, 32'h13);
        apb(1'b1, EBP_CMD_OFS, 32'h3);
        wait_idle;
        chk({30'h0, saw_lo, saw_hi}, 32'h1);
        apb(1'b1, EBP_ADDR_OFS, 32'h10);
        apb(1'b1, EBP_CMD_OFS, 32'h5);
        wait_idle;
        rdm(EBP_RDATA_OFS, 32'hFFFF, 32'hBEEF);
        chk({8'h0, cap_cs, cap_addr}, {8'h0, 4'b1110, 20'h00010});
        // Sixteen-bit multiplexed bus: A0 stays driven, data bits 6:0 ride on port two pins 7:1.
        muxed <= 1'b1;
        apb(1'b1, EBP_CTRL_OFS, 32'h2);
        apb(1'b1, EBP_ADDR_OFS, 32'h1234);
        apb(1'b1, EBP_WDATA_OFS, 32'hC3);
        apb(1'b1, EBP_CMD_OFS, 32'h3);
        wait_idle;
        chk({12'h0, cap_addr}, 32'h01234);
        apb(1'b1, EBP_CMD_OFS, 32'h1);
        wait_idle;
        // Data bit 7 comes back on a released port three pin with no pull-up, so it is masked.
        rdm(EBP_RDATA_OFS, 32'h7F, 32'h43);
        print_verdict;
    end

    // Watchdog: the whole sequence needs well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        print_verdict;
    end
endmodule
`default_nettype wire
